/* common/aocf_pkg.sv */
// Package with register map, field layouts and code tables of the angle output configuration bank.
package aocf_pkg;
    localparam logic [5:0] ADDR_RANGE_DET = 6'h00;
    localparam logic [5:0] ADDR_SPAN = 6'h04;
    localparam logic [5:0] ADDR_CATEGORY = 6'h08;
    localparam logic [5:0] ADDR_LIMITS = 6'h0c;
    localparam logic [5:0] ADDR_STATUS = 6'h10;
    localparam logic [5:0] ADDR_MASK = 6'h14;
    localparam logic [5:0] ADDR_FORMAT = 6'h18;

    localparam logic [15:0] RANGE_DET_RST = 16'h0000;
    localparam logic [12:0] SPAN_RST = 13'h1200;
    localparam int SPAN_W = 13;
    localparam logic [3:0] CATEGORY_RST = 4'h0;
    localparam logic [2:0] FORMAT_RST = 3'h4;
    localparam logic [4:0] TEMP_THR_RST = 5'h1f;
    localparam logic [15:0] LIMITS_RST = {2'h0, 2'h0, 5'h1f, 3'h0, 2'h0, 2'h0};

    // Field positions inside the thermal and supply limits register.
    localparam int LIM_UV_HI = 15;
    localparam int LIM_UV_LO = 14;
    localparam int LIM_LV_HI = 13;
    localparam int LIM_LV_LO = 12;
    localparam int LIM_TT_HI = 11;
    localparam int LIM_TT_LO = 7;
    localparam int LIM_TEMP_WARN = 6;
    localparam int LIM_SBE_WARN = 5;
    localparam int LIM_SUP_WARN = 4;
    localparam int LIM_MASK_HI = 3;
    localparam int LIM_MASK_LO = 2;
    localparam int LIM_SLOPE_HI = 1;
    localparam int LIM_SLOPE_LO = 0;

    // Status and mask bits.
    localparam int NUM_EVT = 3;
    localparam int EVT_TEMP = 0;
    localparam int EVT_SBE = 1;
    localparam int EVT_SUP = 2;

    localparam logic [3:0] STATUS_NIB_MASK = 4'hc;

    typedef enum logic [2:0] {
        AOCF_FMT_A1 = 3'h0,
        AOCF_FMT_A3 = 3'h1,
        AOCF_FMT_H1 = 3'h2,
        AOCF_FMT_H3 = 3'h3,
        AOCF_FMT_H4 = 3'h4
    } aocf_fmt_t;

    localparam logic [11:0] CAT_CODE_0 = 12'h051;
    localparam logic [11:0] CAT_CODE_1 = 12'h052;
    localparam logic [11:0] CAT_CODE_2 = 12'h053;
    localparam logic [11:0] CAT_CODE_3 = 12'h054;
    localparam logic [11:0] CAT_CODE_4 = 12'h055;
    localparam logic [11:0] CAT_CODE_5 = 12'h056;
    localparam logic [11:0] CAT_CODE_6 = 12'h059;
    localparam logic [11:0] CAT_CODE_7 = 12'h05a;
    localparam logic [11:0] CAT_CODE_8 = 12'h062;
    localparam logic [11:0] CAT_CODE_9 = 12'h063;
    localparam logic [11:0] CAT_CODE_10 = 12'h064;
    localparam logic [11:0] CAT_CODE_11 = 12'h066;
    localparam logic [11:0] CAT_CODE_NONE = 12'h000;

    // Legal data range of the fast channel per format.
    localparam logic [11:0] DATA_MIN_A1 = 12'h001;
    localparam logic [11:0] DATA_MAX_A1 = 12'hffe;
    localparam logic [11:0] DATA_MIN_A3 = 12'h000;
    localparam logic [11:0] DATA_MAX_A3 = 12'hfff;
    localparam logic [11:0] DATA_MIN_H = 12'h001;
    localparam logic [11:0] DATA_MAX_H = 12'hff8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* hw/aocf_regs.sv */
// Angle output configuration register bank with AXI4-Lite slave and SENT data limiter.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
module aocf_regs #(
    parameter int ADDR_W = 6
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic temp_over_evt,
    input wire logic bit_error_evt,
    input wire logic supply_fault_evt,
    input wire logic [11:0] raw_data,
    input wire logic [3:0] raw_status_nibble,
    output logic [11:0] sent_data,
    output logic [3:0] sent_status_nibble,
    output logic [11:0] category_code,
    output logic [2:0] frame_format,
    output logic [15:0] range_angle,
    output logic [12:0] span_out,
    output logic irq
);
    logic [15:0] range_q;
    logic [12:0] span_q;
    logic [3:0] cat_q;
    logic [2:0] fmt_q;
    logic [15:0] lim_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [2:0] evt_raw;
    logic [2:0] evt_in;
    logic [2:0] w1c;
    logic [11:0] clip_min;
    logic [11:0] clip_max;
    logic [15:0] span_wr;

    function automatic logic [11:0] cat_code(input logic [3:0] sel);
        case (sel)
            4'h0: cat_code = aocf_pkg::CAT_CODE_0;
            4'h1: cat_code = aocf_pkg::CAT_CODE_1;
            4'h2: cat_code = aocf_pkg::CAT_CODE_2;
            4'h3: cat_code = aocf_pkg::CAT_CODE_3;
            4'h4: cat_code = aocf_pkg::CAT_CODE_4;
            4'h5: cat_code = aocf_pkg::CAT_CODE_5;
            4'h6: cat_code = aocf_pkg::CAT_CODE_6;
            4'h7: cat_code = aocf_pkg::CAT_CODE_7;
            4'h8: cat_code = aocf_pkg::CAT_CODE_8;
            4'h9: cat_code = aocf_pkg::CAT_CODE_9;
            4'ha: cat_code = aocf_pkg::CAT_CODE_10;
            4'hb: cat_code = aocf_pkg::CAT_CODE_11;
            default: cat_code = aocf_pkg::CAT_CODE_NONE;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
        word_addr = {a[ADDR_W-1:2], 2'b00};
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Write channel: address and data are taken in either order, held until both are present.
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    // The top three span bits have no storage; only the span field is kept.
    assign span_wr = merge16({3'h0, span_q}, wdata_q, wstrb_q);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= aocf_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready;
            s_axi_wready <= !w_held_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= word_addr(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    aocf_pkg::ADDR_RANGE_DET, aocf_pkg::ADDR_SPAN, aocf_pkg::ADDR_CATEGORY,
                    aocf_pkg::ADDR_LIMITS, aocf_pkg::ADDR_STATUS, aocf_pkg::ADDR_MASK,
                    aocf_pkg::ADDR_FORMAT: s_axi_bresp <= aocf_pkg::RESP_OKAY;
                    default: s_axi_bresp <= aocf_pkg::RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    // Configuration registers.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            range_q <= aocf_pkg::RANGE_DET_RST;
            span_q <= aocf_pkg::SPAN_RST;
            cat_q <= aocf_pkg::CATEGORY_RST;
            fmt_q <= aocf_pkg::FORMAT_RST;
            lim_q <= aocf_pkg::LIMITS_RST;
            mask_q <= 3'h0;
        end else if (do_write) begin
            case (awaddr_q)
                aocf_pkg::ADDR_RANGE_DET: range_q <= merge16(range_q, wdata_q, wstrb_q);
                aocf_pkg::ADDR_SPAN: span_q <= span_wr[aocf_pkg::SPAN_W-1:0];
                aocf_pkg::ADDR_CATEGORY: begin
                    if (wstrb_q[0]) begin
                        cat_q <= wdata_q[3:0];
                    end
                end
                aocf_pkg::ADDR_FORMAT: begin
                    if (wstrb_q[0]) begin
                        fmt_q <= wdata_q[2:0];
                    end
                end
                aocf_pkg::ADDR_LIMITS: lim_q <= merge16(lim_q, wdata_q, wstrb_q);
                aocf_pkg::ADDR_MASK: begin
                    if (wstrb_q[0]) begin
                        mask_q <= wdata_q[2:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Events come from outside this clock domain, so each passes two flip-flops first.
    logic [2:0] evt_s1_q;
    logic [2:0] evt_s2_q;
    logic [2:0] evt_s3_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            evt_s1_q <= 3'h0;
            evt_s2_q <= 3'h0;
            evt_s3_q <= 3'h0;
        end else begin
            evt_s1_q <= {supply_fault_evt, bit_error_evt, temp_over_evt};
            evt_s2_q <= evt_s1_q;
            evt_s3_q <= evt_s2_q;
        end
    end

    // Each warning enable gates its event; a rising edge sets the sticky bit.
    assign evt_raw = evt_s2_q & ~evt_s3_q;
    assign evt_in = evt_raw & {lim_q[aocf_pkg::LIM_SUP_WARN], lim_q[aocf_pkg::LIM_SBE_WARN],
                               lim_q[aocf_pkg::LIM_TEMP_WARN]};
    assign w1c = (do_write && awaddr_q == aocf_pkg::ADDR_STATUS && wstrb_q[0]) ? wdata_q[2:0] : 3'h0;

    genvar gi;
    generate
        for (gi = 0; gi < aocf_pkg::NUM_EVT; gi++) begin : g_sticky
            // Setting wins over a clear in the same cycle so no event is lost.
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    status_q[gi] <= 1'b0;
                end else if (evt_in[gi]) begin
                    status_q[gi] <= 1'b1;
                end else if (w1c[gi]) begin
                    status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // Read channel.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= aocf_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= aocf_pkg::RESP_OKAY;
                case (word_addr(s_axi_araddr))
                    aocf_pkg::ADDR_RANGE_DET: s_axi_rdata <= {16'h0000, range_q};
                    aocf_pkg::ADDR_SPAN: s_axi_rdata <= {19'h0, span_q};
                    aocf_pkg::ADDR_CATEGORY: s_axi_rdata <= {4'h0, cat_code(cat_q), 12'h000, cat_q};
                    aocf_pkg::ADDR_LIMITS: s_axi_rdata <= {16'h0000, lim_q};
                    aocf_pkg::ADDR_STATUS: s_axi_rdata <= {29'h0, status_q};
                    aocf_pkg::ADDR_MASK: s_axi_rdata <= {29'h0, mask_q};
                    aocf_pkg::ADDR_FORMAT: s_axi_rdata <= {29'h0, fmt_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= aocf_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Data limiter: the H formats keep the top codes free for diagnostics.
    always_comb begin
        case (aocf_pkg::aocf_fmt_t'(fmt_q))
            aocf_pkg::AOCF_FMT_A1: begin
                clip_min = aocf_pkg::DATA_MIN_A1;
                clip_max = aocf_pkg::DATA_MAX_A1;
            end
            aocf_pkg::AOCF_FMT_A3: begin
                clip_min = aocf_pkg::DATA_MIN_A3;
                clip_max = aocf_pkg::DATA_MAX_A3;
            end
            default: begin
                clip_min = aocf_pkg::DATA_MIN_H;
                clip_max = aocf_pkg::DATA_MAX_H;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sent_data <= 12'h000;
            sent_status_nibble <= 4'h0;
            category_code <= aocf_pkg::CAT_CODE_0;
            frame_format <= aocf_pkg::FORMAT_RST;
            range_angle <= aocf_pkg::RANGE_DET_RST;
            span_out <= aocf_pkg::SPAN_RST;
        end else begin
            if (raw_data < clip_min) begin
                sent_data <= clip_min;
            end else if (raw_data > clip_max) begin
                sent_data <= clip_max;
            end else begin
                sent_data <= raw_data;
            end
            sent_status_nibble <= raw_status_nibble &
                (lim_q[aocf_pkg::LIM_MASK_HI:aocf_pkg::LIM_MASK_LO] != 2'h0 ?
                 aocf_pkg::STATUS_NIB_MASK : 4'hf);
            category_code <= cat_code(cat_q);
            frame_format <= fmt_q;
            range_angle <= range_q;
            span_out <= span_q;
        end
    end

    a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
        |(status_q & mask_q) |=> irq)
        else $error("irq not raised for unmasked status");
    a_cat_map: assert property (@(posedge sys_clk) disable iff (!rstn)
        $stable(cat_q) && cat_q == 4'h0 |=> category_code == 12'h051)
        else $error("category zero code wrong");
    a_cat_new: assert property (@(posedge sys_clk) disable iff (!rstn)
        $stable(cat_q) && cat_q == 4'ha |=> category_code == 12'h064)
        else $error("category ten code wrong");
    a_cat_rsvd: assert property (@(posedge sys_clk) disable iff (!rstn)
        $stable(cat_q) && cat_q >= 4'hd |=> category_code == 12'h000)
        else $error("reserved category not zero");
    a_h_clip: assert property (@(posedge sys_clk) disable iff (!rstn)
        fmt_q == 3'h2 |=> sent_data <= 12'hff8 && sent_data >= 12'h001)
        else $error("H format data out of range");
    a_h4_clip: assert property (@(posedge sys_clk) disable iff (!rstn)
        fmt_q == 3'h4 && raw_data == 12'hfff |=> sent_data == 12'hff8)
        else $error("H.4 top code not limited");
    a_span_top: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(word_addr(s_axi_araddr)) == aocf_pkg::ADDR_SPAN
        |-> s_axi_rdata[15:13] == 3'h0)
        else $error("span top bits not zero");
    a_nib_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
        lim_q[3:2] != 2'h0 |=> sent_status_nibble[1:0] == 2'h0)
        else $error("status nibble bits not masked");
    a_warn_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        evt_raw[0] && !lim_q[6] && !status_q[0] |=> !status_q[0])
        else $error("disabled warning set status");
    a_bresp_once: assert property (@(posedge sys_clk) disable iff (!rstn)
        do_write |=> s_axi_bvalid ##0 !do_write)
        else $error("write response missing");
endmodule

/* sim/aocf_data_src.sv */
// Fast channel source model that feeds samples and status nibbles to the bank.
module aocf_data_src (
    input wire logic sys_clk,
    input wire logic rstn,
    output logic [11:0] raw_data,
    output logic [3:0] raw_status_nibble,
    output logic [11:0] prev_data,
    output logic [3:0] prev_nibble
);
    timeunit 1ns;
    timeprecision 1ps;
    // Range ends come back often so the limiter boundaries are hit in every format.
    localparam logic [11:0] CORNER [6] = '{12'h000, 12'h001, 12'hff8, 12'hff9, 12'hffe, 12'hfff};
    logic [2:0] k_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            k_q <= 3'h0;
            raw_data <= 12'h000;
            raw_status_nibble <= 4'h0;
            prev_data <= 12'h000;
            prev_nibble <= 4'h0;
        end else begin
            k_q <= k_q + 3'h1;
            raw_data <= (k_q < 3'h6) ? CORNER[k_q] : 12'($urandom);
            raw_status_nibble <= 4'($urandom);
            prev_data <= raw_data;
            prev_nibble <= raw_status_nibble;
        end
    end
endmodule

/* sim/test_angle_output_config_fields.sv */
// Self-checking bench for the angle output configuration register bank.
module test_angle_output_config_fields;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [2:0] evt = 3'h0;
    logic temp_over_evt, bit_error_evt, supply_fault_evt;
    logic [11:0] raw_data, sent_data, category_code, prev_data;
    logic [3:0] raw_status_nibble, sent_status_nibble, prev_nibble;
    logic [2:0] frame_format;
    logic [15:0] range_angle, lim;
    logic [12:0] span_out;
    int miscompares = 0;
    int tests_run = 0;
    assign temp_over_evt = evt[0];
    assign bit_error_evt = evt[1];
    assign supply_fault_evt = evt[2];

    always #2 sys_clk = ~sys_clk;

    aocf_regs aocf_regs_inst (
        .sys_clk(sys_clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .temp_over_evt(temp_over_evt), .bit_error_evt(bit_error_evt), .supply_fault_evt(supply_fault_evt),
        .raw_data(raw_data), .raw_status_nibble(raw_status_nibble),
        .sent_data(sent_data), .sent_status_nibble(sent_status_nibble), .category_code(category_code),
        .frame_format(frame_format), .range_angle(range_angle), .span_out(span_out), .irq(irq)
    );
    aocf_data_src aocf_data_src_inst (
        .sys_clk(sys_clk), .rstn(rstn), .raw_data(raw_data), .raw_status_nibble(raw_status_nibble),
        .prev_data(prev_data), .prev_nibble(prev_nibble)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        bit fin;
        fin = 0;
        r = 2'bxx;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!fin) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                fin = 1;
            end
        end
        tick(1);
    endtask

    task automatic rdx(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        bit fin;
        fin = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!fin) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                fin = 1;
            end
        end
        tick(1);
    endtask

    function automatic logic [11:0] cat_code(input int s);
        logic [11:0] t [16];
        t = '{12'h051, 12'h052, 12'h053, 12'h054, 12'h055, 12'h056, 12'h059, 12'h05a,
              12'h062, 12'h063, 12'h064, 12'h066, 12'h000, 12'h000, 12'h000, 12'h000};
        return t[s];
    endfunction

    function automatic logic [11:0] limit(input int f, input logic [11:0] v);
        logic [11:0] lo, hi;
        lo = (f == 1) ? 12'h000 : 12'h001;
        hi = (f == 0) ? 12'hffe : (f == 1) ? 12'hfff : 12'hff8;
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The tests need under a thousand cycles; the bus tasks wait without limit, so this is the only escape.
    initial begin
        tick(50000);
        miscompares++;
        summarize();
    end

    initial begin
        void'($urandom(22));
        tick(8);
        rstn <= 1'b1;
        tick(2);
        rdx(aocf_pkg::ADDR_RANGE_DET, rd, rsp);
        check("range reset", 32'h0, rd);
        rdx(aocf_pkg::ADDR_SPAN, rd, rsp);
        check("span reset", 32'h1200, rd);
        rdx(aocf_pkg::ADDR_LIMITS, rd, rsp);
        check("limits reset", 32'h0f80, rd);
        rdx(aocf_pkg::ADDR_FORMAT, rd, rsp);
        check("format reset", 32'h4, rd);
        rdx(aocf_pkg::ADDR_CATEGORY, rd, rsp);
        check("category reset", 32'h051, {20'h0, rd[27:16]});
        $display("test reset values done");
        wr(aocf_pkg::ADDR_RANGE_DET, 32'h8000, rsp);
        check("range write response", 32'(aocf_pkg::RESP_OKAY), {30'h0, rsp});
        rdx(aocf_pkg::ADDR_RANGE_DET, rd, rsp);
        check("range read response", 32'(aocf_pkg::RESP_OKAY), {30'h0, rsp});
        check("range", 32'h8000, rd);
        check("range out", 32'h8000, {16'h0, range_angle});
        // Only the low byte lane is enabled, so the upper byte must keep its old value.
        s_axi_wstrb <= 4'h1;
        wr(aocf_pkg::ADDR_RANGE_DET, 32'h12ab, rsp);
        s_axi_wstrb <= 4'hf;
        rdx(aocf_pkg::ADDR_RANGE_DET, rd, rsp);
        check("range low lane", 32'h80ab, rd);
        // The span is the upper clamp level minus the lower one, with the undefined top bits zero.
        wr(aocf_pkg::ADDR_SPAN, 32'h1300 - 32'h0200, rsp);
        rdx(aocf_pkg::ADDR_SPAN, rd, rsp);
        check("span", 32'h1100, {16'h0, 3'h0, rd[12:0]});
        check("span out", 32'h1100, {19'h0, span_out});
        $display("test range and span done");
        for (int s = 0; s < 16; s++) begin
            // Selection 1100b is never loaded; 1101b to 1111b have no defined code either and are loaded and checked for code zero.
            if (s == 12) continue;
            wr(aocf_pkg::ADDR_CATEGORY, 32'(s), rsp);
            rdx(aocf_pkg::ADDR_CATEGORY, rd, rsp);
            check("category code", {20'h0, cat_code(s)}, {20'h0, rd[27:16]});
            check("category out", {20'h0, cat_code(s)}, {20'h0, category_code});
        end
        $display("test category codes done");
        for (int f = 0; f < 5; f++) begin
            wr(aocf_pkg::ADDR_FORMAT, 32'(f), rsp);
            tick(2);
            check("format out", 32'(f), {29'h0, frame_format});
            repeat (40) begin
                @(posedge sys_clk);
                #1;
                check("sent data", {20'h0, limit(f, prev_data)}, {20'h0, sent_data});
            end
            tick(1);
        end
        $display("test frame formats done");
        for (int i = 0; i < 8; i++) begin
            lim = 16'($urandom);
            lim[3:2] = 2'(i);
            wr(aocf_pkg::ADDR_LIMITS, {16'h0, lim}, rsp);
            rdx(aocf_pkg::ADDR_LIMITS, rd, rsp);
            check("limits", {16'h0, lim}, rd);
            @(posedge sys_clk);
            #1;
            check("status nibble", {28'h0, prev_nibble[3:2], (lim[3:2] != 2'h0) ? 2'h0 : prev_nibble[1:0]},
                {28'h0, sent_status_nibble});
            tick(1);
        end
        $display("test limits and status mask done");
        wr(aocf_pkg::ADDR_LIMITS, 32'h0ff0, rsp);
        for (int e = 0; e < 4; e++) begin
            wr(aocf_pkg::ADDR_MASK, (e < 3) ? 32'h7 : 32'h0, rsp);
            evt <= 3'(1 << (e % 3));
            tick(4);
            evt <= 3'h0;
            tick(10);
            check("irq raised", (e < 3) ? 32'h1 : 32'h0, {31'h0, irq});
            rdx(aocf_pkg::ADDR_STATUS, rd, rsp);
            check("status", 32'(1 << (e % 3)), rd);
            wr(aocf_pkg::ADDR_STATUS, 32'(1 << (e % 3)), rsp);
            tick(3);
            check("irq cleared", 32'h0, {31'h0, irq});
        end
        // With every warning enable clear, no event may reach the status bits.
        wr(aocf_pkg::ADDR_LIMITS, 32'h0f80, rsp);
        wr(aocf_pkg::ADDR_MASK, 32'h7, rsp);
        evt <= 3'h7;
        tick(4);
        evt <= 3'h0;
        tick(10);
        check("irq disabled", 32'h0, {31'h0, irq});
        rdx(aocf_pkg::ADDR_STATUS, rd, rsp);
        check("status disabled", 32'h0, rd);
        $display("test interrupts done");
        wr(6'h1c, 32'h1234, rsp);
        check("unmapped write", 32'(aocf_pkg::RESP_SLVERR), {30'h0, rsp});
        rdx(6'h1c, rd, rsp);
        check("unmapped read", 32'(aocf_pkg::RESP_SLVERR), {30'h0, rsp});
        $display("test unmapped access done");
        summarize();
    end
endmodule
